// >>> hdl/adc_port_defs.svh
// Timing and format constants shared by both ends of the converter readout port.
// Assumes a 25 MHz system clock on both ends.
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH

// System clock period
`define CLK_PERIOD_NS 40
// Convert edge to data available, least and longest
`define CONV_MIN_NS 300
`define CONV_MAX_NS 500
`define CONV_MIN_CYC ((`CONV_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_MAX_CYC (`CONV_MAX_NS / `CLK_PERIOD_NS)
// Result word and chain delay in serial clock cycles
`define RESULT_BITS 16
`define CHAIN_DELAY_BITS 16
// Host side pacing: serial clock half period, wait before readout
`define SCK_HALF_CYC 4
`define CONV_WAIT_CYC (`CONV_MAX_CYC + 4)
`define LEAD_CYC 8

`endif

// >>> hdl/adc_port_pkg.sv
// Types shared by both ends of the converter readout port.
// Assumes nothing beyond the constants header.
package adc_port_pkg;
  // Interface mode chosen at each convert rising edge
  typedef enum logic {MODE_CS = 1'b0, MODE_CHAIN = 1'b1} mode_e;
  // Device sequencing
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_CONV = 2'b01,
    DEV_READY = 2'b10
  } dev_state_e;
  // Host sequencing
  typedef enum logic [2:0] {
    HOST_IDLE = 3'b000,
    HOST_SETUP = 3'b001,
    HOST_CONV = 3'b010,
    HOST_LEAD = 3'b011,
    HOST_CLK = 3'b100,
    HOST_DONE = 3'b101
  } host_state_e;
endpackage

// >>> hdl/adc_link_if.sv
// Serial link between converter port and host.
// The result line is three-state; a released line reads high (pull-up).
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic convert_strobe;
  logic serial_clk;
  logic serial_chain_in;
  logic serial_result_out;
  logic serial_result_oe;
  logic serial_result_line;

  // Resolved level of the result wire
  assign serial_result_line = serial_result_oe ? serial_result_out : 1'b1;

  modport device (
    input convert_strobe,
    input serial_clk,
    input serial_chain_in,
    output serial_result_out,
    output serial_result_oe
  );
  modport host (
    output convert_strobe,
    output serial_clk,
    output serial_chain_in,
    input serial_result_line
  );
endinterface
`default_nettype wire

// >>> hdl/adc_port_device.sv
// Converter end of the serial readout port: conversion timing, mode choice,
// chip-select style and daisy-chain shifting, busy indication.
// Assumes all link pins are asynchronous to clk_sys and that sample_value
// holds the digitised input, already straight binary, on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_defs.svh"

module adc_port_device
  import adc_port_pkg::*;
#(
  parameter int RESULT_W = `RESULT_BITS,
  parameter int CONV_CYC = `CONV_MIN_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  adc_link_if.device link,
  input wire logic [RESULT_W-1:0] sample_value,
  output logic conv_busy,
  output logic conv_done,
  output logic chain_mode,
  output logic busy_ind
);
  localparam int CW = $clog2(RESULT_W + 2);
  localparam logic [4:0] CONV_LAST = 5'(CONV_CYC - 1);
  localparam logic [CW-1:0] BITS_W = CW'(RESULT_W);

  // Two-stage synchronisers plus an edge history stage
  logic [2:0] cnv_sy;
  logic [2:0] sck_sy;
  logic [2:0] sdi_sy;
  logic cnv_s;
  logic sck_s;
  logic sdi_s;
  logic cnv_rise;
  logic sck_fall;
  logic select_cs;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnv_sy <= 3'h0;
      sck_sy <= 3'h0;
      sdi_sy <= 3'h7;
    end else begin
      cnv_sy <= {cnv_sy[1:0], link.convert_strobe};
      sck_sy <= {sck_sy[1:0], link.serial_clk};
      sdi_sy <= {sdi_sy[1:0], link.serial_chain_in};
    end
  end

  // Edges and levels seen after synchronisation
  assign cnv_s = cnv_sy[1];
  assign sck_s = sck_sy[1];
  assign sdi_s = sdi_sy[1];
  assign cnv_rise = cnv_sy[1] & ~cnv_sy[2];
  assign sck_fall = ~sck_sy[1] & sck_sy[2];
  assign select_cs = ~cnv_s | ~sdi_s;

  // Sequencer state
  dev_state_e state_reg, state_next;
  mode_e mode_reg, mode_next;
  logic busy_en_reg, busy_en_next;
  logic [4:0] conv_cnt_reg, conv_cnt_next;
  logic [RESULT_W-1:0] sample_reg, sample_next;
  logic [RESULT_W:0] shift_reg, shift_next;
  logic [CW-1:0] bits_left_reg, bits_left_next;
  logic first_reg, first_next;
  logic sdo_reg, sdo_next;
  logic oe_reg, oe_next;
  logic done_reg, done_next;
  logic conv_busy_reg, conv_busy_next;

  // Next-state logic for conversion and shifting
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    busy_en_next = busy_en_reg;
    conv_cnt_next = conv_cnt_reg;
    sample_next = sample_reg;
    shift_next = shift_reg;
    bits_left_next = bits_left_reg;
    first_next = first_reg;
    sdo_next = sdo_reg;
    oe_next = oe_reg;
    done_next = 1'b0;
    if (cnv_rise) begin
      // Mode from the chain input level at the convert edge
      mode_next = sdi_s ? MODE_CS : MODE_CHAIN;
      // Chain busy chosen by a high serial clock at the edge
      busy_en_next = ~sdi_s & sck_s;
      sample_next = sample_value;
      conv_cnt_next = 5'h00;
      state_next = DEV_CONV;
      bits_left_next = '0;
      sdo_next = 1'b0;
      oe_next = ~sdi_s; // Chain output stays driven, CS output released
    end else begin
      unique case (state_reg)
        DEV_IDLE: begin
          oe_next = 1'b0;
        end
        DEV_CONV: begin
          conv_cnt_next = conv_cnt_reg + 5'h01;
          if (conv_cnt_reg == CONV_LAST) begin
            state_next = DEV_READY;
            done_next = 1'b1;
            first_next = 1'b1;
            if (mode_reg == MODE_CS) begin
              busy_en_next = select_cs;
              if (select_cs) begin
                // Busy slot low ahead of the word
                shift_next = {1'b0, sample_reg};
                bits_left_next = BITS_W + CW'(1);
              end else begin
                shift_next = {sample_reg, 1'b0};
                bits_left_next = BITS_W;
              end
              oe_next = select_cs;
              sdo_next = shift_next[RESULT_W];
            end else begin
              shift_next = {sample_reg, 1'b0};
              bits_left_next = BITS_W;
              oe_next = 1'b1;
              sdo_next = busy_en_reg ? sdi_s : sample_reg[RESULT_W-1];
            end
          end
        end
        DEV_READY: begin
          if (mode_reg == MODE_CS) begin
            if (!select_cs || bits_left_reg == '0) begin
              oe_next = 1'b0;
            end else if (sck_fall) begin
              shift_next = {shift_reg[RESULT_W-1:0], 1'b0};
              bits_left_next = bits_left_reg - CW'(1);
              sdo_next = shift_next[RESULT_W];
              oe_next = (bits_left_reg != CW'(1));
            end else begin
              oe_next = 1'b1;
              sdo_next = shift_reg[RESULT_W];
            end
          end else begin
            oe_next = 1'b1;
            if (sck_fall) begin
              // Chain input enters at the bottom, leaves 16 falls later
              shift_next = {shift_reg[RESULT_W-1:0], sdi_s};
              sdo_next = shift_next[RESULT_W];
              first_next = 1'b0;
            end else if (busy_en_reg && first_reg) begin
              // Upstream completion passed on before the first fall
              sdo_next = sdi_s ? 1'b1 : shift_reg[RESULT_W];
            end
          end
        end
        default: begin
          state_next = DEV_IDLE;
        end
      endcase
    end
    conv_busy_next = (state_next == DEV_CONV);
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= DEV_IDLE;
      mode_reg <= MODE_CS;
      busy_en_reg <= 1'b0;
      conv_cnt_reg <= 5'h00;
      sample_reg <= '0;
      shift_reg <= '0;
      bits_left_reg <= '0;
      first_reg <= 1'b0;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      done_reg <= 1'b0;
      conv_busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      busy_en_reg <= busy_en_next;
      conv_cnt_reg <= conv_cnt_next;
      sample_reg <= sample_next;
      shift_reg <= shift_next;
      bits_left_reg <= bits_left_next;
      first_reg <= first_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
      done_reg <= done_next;
      conv_busy_reg <= conv_busy_next;
    end
  end

  // Outputs straight from flip-flops
  assign link.serial_result_out = sdo_reg;
  assign link.serial_result_oe = oe_reg;
  assign conv_busy = conv_busy_reg;
  assign conv_done = done_reg;
  assign chain_mode = mode_reg;
  assign busy_ind = busy_en_reg;
endmodule
`default_nettype wire

// >>> hdl/adc_port_host.sv
// Host end of the converter readout port: starts a conversion, then
// clocks one 16-bit result in, in chip-select style or daisy-chain mode.
// Assumes the result line is asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_defs.svh"

module adc_port_host
  import adc_port_pkg::*;
#(
  parameter int RESULT_W = `RESULT_BITS,
  parameter int HALF_CYC = `SCK_HALF_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  adc_link_if.host link,
  input wire logic start,
  input wire logic use_chain,
  output logic [RESULT_W-1:0] result,
  output logic result_valid,
  output logic host_busy
);
  localparam logic [4:0] WAIT_LAST = 5'(`CONV_WAIT_CYC - 1);
  localparam logic [4:0] LEAD_LAST = 5'(`LEAD_CYC - 1);
  localparam logic [4:0] HALF_LAST = 5'(HALF_CYC - 1);
  localparam logic [4:0] BIT_LAST = 5'(RESULT_W - 1);

  // Result line synchroniser
  logic [1:0] sdo_sy;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sdo_sy <= 2'h3;
    end else begin
      sdo_sy <= {sdo_sy[0], link.serial_result_line};
    end
  end

  host_state_e state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [4:0] bit_reg, bit_next;
  logic chain_reg, chain_next;
  logic cnv_reg, cnv_next;
  logic sck_reg, sck_next;
  logic sdi_reg, sdi_next;
  logic [RESULT_W-1:0] shift_reg, shift_next;
  logic [RESULT_W-1:0] result_reg, result_next;
  logic valid_reg, valid_next;
  logic busy_reg, busy_next;

  // Transfer sequencing and serial clock divider
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 5'h01;
    bit_next = bit_reg;
    chain_next = chain_reg;
    cnv_next = cnv_reg;
    sck_next = sck_reg;
    sdi_next = sdi_reg;
    shift_next = shift_reg;
    result_next = result_reg;
    valid_next = 1'b0;
    unique case (state_reg)
      HOST_IDLE: begin
        if (start) begin
          chain_next = use_chain;
          sdi_next = ~use_chain; // Mode level set ahead of the edge
          sck_next = 1'b0;
          state_next = HOST_SETUP;
        end
      end
      HOST_SETUP: begin
        cnv_next = 1'b1;
        cnt_next = 5'h00;
        state_next = HOST_CONV;
      end
      HOST_CONV: begin
        if (cnt_reg == WAIT_LAST) begin
          cnv_next = chain_reg; // CS style selects by low convert
          cnt_next = 5'h00;
          state_next = HOST_LEAD;
        end
      end
      HOST_LEAD: begin
        if (cnt_reg == LEAD_LAST) begin
          sck_next = 1'b1;
          cnt_next = 5'h00;
          bit_next = 5'h00;
          state_next = HOST_CLK;
        end
      end
      HOST_CLK: begin
        if (cnt_reg == HALF_LAST) begin
          cnt_next = 5'h00;
          sck_next = ~sck_reg;
          if (sck_reg) begin
            // Capture the bit still shown at our falling edge
            shift_next = {shift_reg[RESULT_W-2:0], sdo_sy[1]};
            bit_next = bit_reg + 5'h01;
            if (bit_reg == BIT_LAST) begin
              state_next = HOST_DONE;
            end
          end
        end
      end
      HOST_DONE: begin
        cnv_next = 1'b0;
        result_next = shift_reg;
        valid_next = 1'b1;
        state_next = HOST_IDLE;
      end
      default: begin
        state_next = HOST_IDLE;
      end
    endcase
    busy_next = (state_next != HOST_IDLE); // Registered so the output is a flop
  end

  // Transfer registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= HOST_IDLE;
      cnt_reg <= 5'h00;
      bit_reg <= 5'h00;
      chain_reg <= 1'b0;
      cnv_reg <= 1'b0;
      sck_reg <= 1'b0;
      sdi_reg <= 1'b1;
      shift_reg <= '0;
      result_reg <= '0;
      valid_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      chain_reg <= chain_next;
      cnv_reg <= cnv_next;
      sck_reg <= sck_next;
      sdi_reg <= sdi_next;
      shift_reg <= shift_next;
      result_reg <= result_next;
      valid_reg <= valid_next;
      busy_reg <= busy_next;
    end
  end

  assign link.convert_strobe = cnv_reg;
  assign link.serial_clk = sck_reg;
  assign link.serial_chain_in = sdi_reg;
  assign result = result_reg;
  assign result_valid = valid_reg;
  assign host_busy = busy_reg;
endmodule
`default_nettype wire

// >>> tb/adc_serial_readout_port_monitor.sv
// Checker for the converter readout link, watching the shared link wires.
// Assumes the host keeps the serial clock low outside readout.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout_port_monitor (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic convert_strobe,
  input wire logic serial_clk,
  input wire logic serial_chain_in,
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  logic cs_reg;
  logic [4:0] fall_reg;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Mode of the current transfer and serial clock falls seen
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cs_reg <= 1'b1;
      fall_reg <= '0;
    end else if ($rose(convert_strobe)) begin
      cs_reg <= serial_chain_in;
      fall_reg <= '0;
    end else if ($fell(serial_clk)) begin
      fall_reg <= fall_reg + 5'h01;
    end
  end

  sck_quiet_conv_a: assert property ($rose(convert_strobe) |->
    (!serial_clk)[*8] ##1 (!serial_clk)[*5]) else $error("serial clock during conversion");
  no_early_data_a: assert property ($rose(convert_strobe) && serial_chain_in |->
    ##5 (!serial_result_oe)[*3]) else $error("result driven too early");
  mode_hold_a: assert property ($rose(convert_strobe) |->
    $stable(serial_chain_in) ##1 $stable(serial_chain_in)) else $error("chain input moved");
  sck_hold_a: assert property (!serial_chain_in && $rose(convert_strobe) |->
    $stable(serial_clk) ##1 $stable(serial_clk)) else $error("serial clock moved at convert");
  data_enable_a: assert property ($fell(convert_strobe) && cs_reg |->
    ##[1:5] serial_result_oe) else $error("output not enabled after select");
  bit_hold_a: assert property (serial_result_oe && $fell(serial_clk) |->
    $stable(serial_result_out)) else $error("bit changed at clock fall");
  last_release_a: assert property (cs_reg && $fell(serial_clk) && fall_reg == 5'h0F |->
    ##[1:6] !serial_result_oe) else $error("output kept after last fall");
  desel_release_a: assert property ((convert_strobe && serial_chain_in)[*6] ##0 cs_reg |->
    !serial_result_oe) else $error("output driven while deselected");

  // Main scenarios
  cover property ($rose(convert_strobe) && serial_chain_in);
  cover property ($rose(convert_strobe) && !serial_chain_in);
  cover property ($fell(serial_clk) && fall_reg == 5'h0F);
endmodule
`default_nettype wire

// >>> tb/adc_serial_readout_port_tb.sv
// Testbench joining host and converter ends over one link.
// Assumes the host paces the link; inputs change at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_defs.svh"
module adc_serial_readout_port_tb;
  import adc_port_pkg::*;
  logic clk_sys, rst_b, start, use_chain, result_valid, host_busy, sck_prev;
  logic conv_busy, conv_done, chain_mode, busy_ind, cnv_prev;
  logic [15:0] sample_value, result, wire_word;
  logic [15:0] corners [4];
  int failures, n_compared, cycles, lat, seed, conv_age, conv_ns, n_done;

  adc_link_if adc_link_if_i();
  adc_port_device adc_port_device_i (.clk_sys(clk_sys), .rst_b(rst_b), .link(adc_link_if_i),
    .sample_value(sample_value), .conv_busy(conv_busy), .conv_done(conv_done),
    .chain_mode(chain_mode), .busy_ind(busy_ind));
  adc_port_host adc_port_host_i (.clk_sys(clk_sys), .rst_b(rst_b), .link(adc_link_if_i),
    .start(start), .use_chain(use_chain), .result(result), .result_valid(result_valid),
    .host_busy(host_busy));
  adc_serial_readout_port_monitor adc_serial_readout_port_monitor_i (.clk_sys(clk_sys),
    .rst_b(rst_b), .convert_strobe(adc_link_if_i.convert_strobe),
    .serial_clk(adc_link_if_i.serial_clk), .serial_chain_in(adc_link_if_i.serial_chain_in),
    .serial_result_out(adc_link_if_i.serial_result_out),
    .serial_result_oe(adc_link_if_i.serial_result_oe));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #(`CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  // Start edge to valid as counted by run: start, setup, wait, lead, clocking, done
  function automatic int readout_cycles();
    return 3 + `CONV_WAIT_CYC + `LEAD_CYC + (2 * `RESULT_BITS - 1) * `SCK_HALF_CYC;
  endfunction

  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Wire capture at each serial clock fall, and hang guard
  always @(posedge clk_sys) begin
    sck_prev <= adc_link_if_i.serial_clk;
    cnv_prev <= adc_link_if_i.convert_strobe;
    // Age of the latest convert rise, and its age when data became ready
    if (cnv_prev === 1'b0 && adc_link_if_i.convert_strobe === 1'b1) begin
      conv_age <= 1;
    end else begin
      conv_age <= conv_age + 1;
    end
    if (conv_done === 1'b1) begin
      conv_ns <= conv_age * `CLK_PERIOD_NS;
      n_done <= n_done + 1;
    end
    if (sck_prev === 1'b1 && adc_link_if_i.serial_clk === 1'b0) begin
      wire_word <= {wire_word[14:0], adc_link_if_i.serial_result_line};
    end
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      failures++;
      summarize();
    end
  end

  // One conversion and readout, with a refused start and a late input change
  task automatic run(input logic chain, input logic [15:0] val);
    int n;
    int done_base;
    logic in_window;
    done_base = n_done;
    @(negedge clk_sys);
    sample_value = val;
    use_chain = chain;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    lat = 1;
    for (n = 0; n < 400 && result_valid !== 1'b1; n++) begin
      start = (n == 20);
      if (n == 20) use_chain = ~chain;
      if (n == 30) sample_value = 16'($random(seed));
      @(negedge clk_sys);
      lat++;
    end
    start = 1'b0;
    check(result, val, "result word");
    check(16'(lat), 16'(readout_cycles()), "start to result");
    in_window = (conv_ns >= `CONV_MIN_NS) && (conv_ns <= `CONV_MAX_NS);
    check(16'(in_window), 16'h0001, "convert to data");
    check(16'(n_done - done_base), 16'h0001, "done pulses");
    check(16'(conv_busy), 16'h0000, "conversion over");
    check(16'(host_busy), 16'h0000, "host idle");
    check(16'(chain_mode), 16'(chain), "mode chosen");
    check(16'(busy_ind), 16'h0000, "busy indication");
    @(negedge clk_sys);
    check(wire_word, val, "bits on wire");
    check(16'(result_valid), 16'h0000, "valid pulse length");
    repeat (4) @(negedge clk_sys);
    if (!chain) check(16'(adc_link_if_i.serial_result_line), 16'h0001, "line released");
  endtask

  // Main sequence
  initial begin
    seed = 32'hE935A850;
    corners = '{16'h0000, 16'hFFFF, 16'h8001, 16'h7FFE};
    failures = 0;
    n_compared = 0;
    cycles = 0;
    sck_prev = 1'b0;
    wire_word = '0;
    rst_b = 1'b0;
    start = 1'b0;
    use_chain = 1'b0;
    sample_value = '0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    for (int i = 0; i < 8; i++) begin
      run(1'(i % 2), corners[i / 2]);
    end
    for (int i = 0; i < 12; i++) begin
      run(1'($random(seed)), 16'($random(seed)));
    end
    summarize();
  end
endmodule
`default_nettype wire
